// ### include/srw_cfg.svh
`ifndef SRW_CFG_SVH
`define SRW_CFG_SVH

// number of supervised power rails
`define SRW_RAILS 10
// internal clock period and the millisecond tick period, both in ns
`define SRW_CLK_NS 8
`define SRW_TICK_NS 1000000
// cycles per millisecond tick, derived from the two times above
`define SRW_TICK_CYC (`SRW_TICK_NS / `SRW_CLK_NS)
`define SRW_TICK_W 17
// system-reset delay selector: code 0 is no delay, code n is 2^(n-1) ms up to code 16; higher codes clamp to 16
`define SRW_DLY_W 5
`define SRW_DLY_MAX_CODE 5'h10
`define SRW_MS_W 16
`define SRW_MS_ONE 16'h0001
// pulse width and watchdog timeout limits in ms (1 ms to 32.256 s)
`define SRW_WIDTH_MIN_MS 16'h0001
`define SRW_WIDTH_MAX_MS 16'h7E00
// initial wait selector: code 0 is none, code n is 100 ms * 2^(n-1)
`define SRW_INIT_W 4
`define SRW_WD_W 22
`define SRW_INIT_UNIT_MS 22'h00_0064
`define SRW_WD_ONE 22'h00_0001
// two pins pass the synchroniser: bit 0 kick, bit 1 release tracking
`define SRW_PINS 2
`define SRW_PIN_KICK 0
`define SRW_PIN_TRACK 1

`endif

// ### include/srw_pkg.sv
`include "srw_cfg.svh"

package srw_pkg;

    // system-reset sequencer states, one-hot
    typedef enum logic [6:0]
    {
        RS_WAIT = 7'h01,
        RS_ON_DLY = 7'h02,
        RS_UP = 7'h04,
        RS_OFF_DLY = 7'h08,
        RS_PULSE = 7'h10,
        RS_WD_RST = 7'h20,
        RS_WD_REL = 7'h40
    } srw_rst_st_t;

    // supervisor timer states, one-hot
    typedef enum logic [3:0]
    {
        WD_OFF = 4'h1,
        WD_INIT = 4'h2,
        WD_RUN = 4'h4,
        WD_EXP = 4'h8
    } srw_wd_st_t;

    // system-reset configuration
    typedef struct packed
    {
        logic [`SRW_RAILS-1:0] rail_sel;
        logic [`SRW_DLY_W-1:0] dly_sel;
        logic pulse_mode;
        logic [`SRW_MS_W-1:0] width_ms;
    } srw_rst_cfg_t;

    // supervisor timer configuration
    typedef struct packed
    {
        logic enable;
        logic tie_reset;
        logic [`SRW_INIT_W-1:0] init_sel;
        logic [`SRW_MS_W-1:0] timeout_ms;
        logic kick_pin_en;
        logic track_en;
    } srw_wd_cfg_t;

    typedef struct packed
    {
        logic [`SRW_PINS-1:0] s1;
        logic [`SRW_PINS-1:0] s2;
    } srw_sync_st_t;

    typedef struct packed
    {
        logic [`SRW_TICK_W-1:0] cnt;
        logic tick;
    } srw_tick_st_t;

    typedef struct packed
    {
        srw_rst_st_t rst_st;
        srw_wd_st_t wd_st;
        logic [`SRW_MS_W-1:0] rst_cnt;
        logic [`SRW_WD_W-1:0] wd_cnt;
        logic kick_d;
        logic wd_fire;
        logic sys_reset;
        logic timeout_out;
    } srw_top_st_t;

    localparam srw_top_st_t SRW_TOP_RST = '{rst_st: RS_WAIT, wd_st: WD_OFF, rst_cnt: '0, wd_cnt: '0,
                                           kick_d: 1'b0, wd_fire: 1'b0, sys_reset: 1'b1, timeout_out: 1'b0};

endpackage

// ### verilog/srw_sync.sv
`include "srw_cfg.svh"

module srw_sync
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [`SRW_PINS-1:0] pin_i,
    output logic [`SRW_PINS-1:0] pin_o
);
    import srw_pkg::*;

    srw_sync_st_t st_ff;
    srw_sync_st_t nxt_st;

    // first stage feeds only the second stage
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.s1 = pin_i;
        nxt_st.s2 = st_ff.s1;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign pin_o = st_ff.s2;
endmodule

// ### verilog/srw_tick.sv
`include "srw_cfg.svh"

module srw_tick
#(
    parameter int TICK_CYC = `SRW_TICK_CYC
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    output logic tick_o
);
    import srw_pkg::*;

    srw_tick_st_t st_ff;
    srw_tick_st_t nxt_st;

    // free-running divider, one-cycle tick each millisecond
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (st_ff.cnt == `SRW_TICK_W'(TICK_CYC - 1))
        begin
            nxt_st.cnt = '0;
            nxt_st.tick = 1'b1;
        end
        else
        begin
            nxt_st.cnt = st_ff.cnt + `SRW_TICK_W'(1);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign tick_o = st_ff.tick;
endmodule

// ### verilog/srw_top.sv
`include "srw_cfg.svh"
module srw_top
#(
    parameter int TICK_CYC = `SRW_TICK_CYC
)
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [`SRW_RAILS-1:0] pg_i,
    input wire srw_pkg::srw_rst_cfg_t rst_cfg_i,
    input wire srw_pkg::srw_wd_cfg_t wd_cfg_i,
    input wire logic kick_input_i,
    input wire logic kick_cmd_i,
    input wire logic track_input_i,
    output logic sys_reset_o,
    output logic timeout_output_o,
    output logic wd_fire_o,
    output srw_pkg::srw_rst_st_t rst_state_o,
    output srw_pkg::srw_wd_st_t wd_state_o
);
    import srw_pkg::*;

    logic rst_meta_ff;
    logic rst_n;
    logic tick;
    logic [`SRW_PINS-1:0] pin_s;
    srw_top_st_t st_ff;
    srw_top_st_t nxt_st;
    logic pg_ok;
    logic kick_evt;
    logic wd_armed;
    logic [`SRW_MS_W-1:0] dly_ms;
    logic [`SRW_MS_W-1:0] width_ms;
    logic [`SRW_MS_W-1:0] tmo_ms;
    logic [`SRW_WD_W-1:0] init_ms;

    // reset release through two flops, assertion stays asynchronous
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rst_meta_ff <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_n <= rst_meta_ff;
        end
    end

    srw_tick #(.TICK_CYC(TICK_CYC)) u_tick
    (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .tick_o(tick)
    );

    srw_sync u_sync
    (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .pin_i({track_input_i, kick_input_i}),
        .pin_o(pin_s)
    );

    // reset delay table: zero, then doubling from one ms; codes above the top clamp
    function automatic logic [`SRW_MS_W-1:0] dly_of(input logic [`SRW_DLY_W-1:0] code);
        logic [`SRW_DLY_W-1:0] c;
        c = (code > `SRW_DLY_MAX_CODE) ? `SRW_DLY_MAX_CODE : code;
        if (c == '0)
        begin
            return '0;
        end
        return `SRW_MS_ONE << (c - `SRW_DLY_W'(1));
    endfunction

    // initial wait table: zero, then 100 ms doubling
    function automatic logic [`SRW_WD_W-1:0] init_of(input logic [`SRW_INIT_W-1:0] code);
        if (code == '0)
        begin
            return '0;
        end
        return `SRW_INIT_UNIT_MS << (code - `SRW_INIT_W'(1));
    endfunction

    // clamp a millisecond setting into the legal 1 ms .. 32.256 s span
    function automatic logic [`SRW_MS_W-1:0] clamp_ms(input logic [`SRW_MS_W-1:0] v);
        if (v < `SRW_WIDTH_MIN_MS)
        begin
            return `SRW_WIDTH_MIN_MS;
        end
        if (v > `SRW_WIDTH_MAX_MS)
        begin
            return `SRW_WIDTH_MAX_MS;
        end
        return v;
    endfunction

    // decoded settings and events; an empty rail selection counts as good
    always_comb
    begin
        dly_ms = dly_of(rst_cfg_i.dly_sel);
        width_ms = clamp_ms(rst_cfg_i.width_ms);
        tmo_ms = clamp_ms(wd_cfg_i.timeout_ms);
        init_ms = init_of(wd_cfg_i.init_sel);
        pg_ok = &(pg_i | ~rst_cfg_i.rail_sel);
        // the pin may be unused, then only the command clears the count
        kick_evt = kick_cmd_i | (wd_cfg_i.kick_pin_en & (pin_s[`SRW_PIN_KICK] ^ st_ff.kick_d));
        // tied to reset, the timer only supervises a released processor
        wd_armed = wd_cfg_i.enable & (~wd_cfg_i.tie_reset | (st_ff.rst_st == RS_UP));
    end

    // next state of both sequencers
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.kick_d = pin_s[`SRW_PIN_KICK];
        nxt_st.wd_fire = 1'b0;
        if (tick)
        begin
            nxt_st.rst_cnt = (&st_ff.rst_cnt) ? st_ff.rst_cnt : st_ff.rst_cnt + `SRW_MS_ONE;
            nxt_st.wd_cnt = (&st_ff.wd_cnt) ? st_ff.wd_cnt : st_ff.wd_cnt + `SRW_WD_ONE;
        end
        // reset sequencer
        case (st_ff.rst_st)
            RS_WAIT:
            begin
                if (pg_ok)
                begin
                    nxt_st.rst_st = RS_ON_DLY;
                    nxt_st.rst_cnt = '0;
                end
            end
            RS_ON_DLY:
            begin
                if (!pg_ok)
                begin
                    nxt_st.rst_st = RS_WAIT;
                end
                else if (st_ff.rst_cnt >= dly_ms)
                begin
                    nxt_st.rst_st = rst_cfg_i.pulse_mode ? RS_PULSE : RS_UP;
                    nxt_st.rst_cnt = '0;
                end
            end
            RS_UP:
            begin
                if (!pg_ok)
                begin
                    // pulse mode rearms at once; level mode waits the common delay
                    nxt_st.rst_st = rst_cfg_i.pulse_mode ? RS_WAIT : RS_OFF_DLY;
                    nxt_st.rst_cnt = '0;
                end
                else if (st_ff.wd_fire && wd_cfg_i.tie_reset)
                begin
                    nxt_st.rst_st = RS_WD_RST;
                    nxt_st.rst_cnt = '0;
                end
            end
            RS_OFF_DLY:
            begin
                if (pg_ok)
                begin
                    nxt_st.rst_st = RS_UP;
                end
                else if (st_ff.rst_cnt >= dly_ms)
                begin
                    nxt_st.rst_st = RS_WAIT;
                end
            end
            RS_PULSE:
            begin
                if (st_ff.rst_cnt >= width_ms)
                begin
                    nxt_st.rst_st = RS_UP;
                end
            end
            RS_WD_RST:
            begin
                if (!pg_ok)
                begin
                    nxt_st.rst_st = RS_WAIT;
                end
                else if (wd_cfg_i.track_en ? pin_s[`SRW_PIN_TRACK] : (st_ff.rst_cnt >= width_ms))
                begin
                    // tracked release still waits the common delay before letting go
                    nxt_st.rst_st = wd_cfg_i.track_en ? RS_WD_REL : RS_UP;
                    nxt_st.rst_cnt = '0;
                end
            end
            RS_WD_REL:
            begin
                if (!pg_ok)
                begin
                    nxt_st.rst_st = RS_WAIT;
                end
                else if (st_ff.rst_cnt >= dly_ms)
                begin
                    nxt_st.rst_st = RS_UP;
                end
            end
            default:
            begin
                nxt_st.rst_st = RS_WAIT;
            end
        endcase
        // supervisor timer; a kick in the expiry cycle wins over the expiry
        if (!wd_armed)
        begin
            nxt_st.wd_st = WD_OFF;
        end
        else
        begin
            case (st_ff.wd_st)
                WD_OFF:
                begin
                    nxt_st.wd_st = WD_INIT;
                    nxt_st.wd_cnt = '0;
                end
                WD_INIT:
                begin
                    if (kick_evt || st_ff.wd_cnt >= init_ms)
                    begin
                        nxt_st.wd_st = WD_RUN;
                        nxt_st.wd_cnt = '0;
                    end
                end
                WD_RUN:
                begin
                    if (kick_evt)
                    begin
                        nxt_st.wd_cnt = '0;
                    end
                    else if (st_ff.wd_cnt >= `SRW_WD_W'(tmo_ms))
                    begin
                        nxt_st.wd_st = WD_EXP;
                        nxt_st.wd_fire = 1'b1;
                    end
                end
                WD_EXP:
                begin
                    if (kick_evt)
                    begin
                        nxt_st.wd_st = WD_RUN;
                        nxt_st.wd_cnt = '0;
                    end
                end
                default:
                begin
                    nxt_st.wd_st = WD_OFF;
                end
            endcase
        end
        // registered pin levels, taken from the next state so they track it exactly
        nxt_st.sys_reset = (~rst_cfg_i.pulse_mode & (nxt_st.rst_st == RS_WAIT || nxt_st.rst_st == RS_ON_DLY))
                         | (nxt_st.rst_st == RS_PULSE) | (nxt_st.rst_st == RS_WD_RST)
                         | (nxt_st.rst_st == RS_WD_REL);
        nxt_st.timeout_out = (nxt_st.wd_st == WD_EXP);
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff <= SRW_TOP_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from the state register
    assign sys_reset_o = st_ff.sys_reset;
    assign timeout_output_o = st_ff.timeout_out;
    assign wd_fire_o = st_ff.wd_fire;
    assign rst_state_o = st_ff.rst_st;
    assign wd_state_o = st_ff.wd_st;

    // checks on the sequencing
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n);

    sequence s_armed_kick;
        kick_evt && wd_armed && (st_ff.wd_st == WD_RUN);
    endsequence

    sequence s_expiry;
        st_ff.wd_fire && wd_cfg_i.tie_reset && (st_ff.rst_st == RS_UP) && pg_ok;
    endsequence

    a_kick_clears_count: assert property (s_armed_kick |=> st_ff.wd_cnt == '0 && st_ff.wd_st == WD_RUN)
        else $error("kick did not clear the timer");
    a_hold_before_good: assert property (!rst_cfg_i.pulse_mode && !pg_ok |=> st_ff.rst_st != RS_UP)
        else $error("reset released without power good");
    a_level_reset_out: assert property (st_ff.rst_st == RS_WAIT && !$past(rst_cfg_i.pulse_mode) |-> sys_reset_o)
        else $error("level reset not asserted while waiting");
    a_pulse_done_width: assert property (st_ff.rst_st == RS_PULSE && st_ff.rst_cnt < width_ms |=>
        st_ff.rst_st == RS_PULSE)
        else $error("reset pulse ended early");
    a_expiry_resets: assert property (s_expiry |=> st_ff.rst_st == RS_WD_RST ##1 sys_reset_o)
        else $error("expiry did not reassert reset");
    a_timeout_pin: assert property ($rose(st_ff.wd_fire) |-> ##1 timeout_output_o)
        else $error("timeout pin not raised after expiry");
    a_init_zero_wait: assert property (st_ff.wd_st == WD_INIT && init_ms == '0 && wd_armed |=>
        st_ff.wd_st == WD_RUN)
        else $error("zero initial wait did not start at once");
    a_tick_spacing: assert property (tick |=> !tick)
        else $error("millisecond tick repeated");
    a_no_early_expiry: assert property (st_ff.wd_st == WD_RUN && st_ff.wd_cnt < `SRW_WD_W'(tmo_ms) |=>
        !st_ff.wd_fire)
        else $error("timer expired before its period");
    a_zero_delay_on: assert property (st_ff.rst_st == RS_ON_DLY && pg_ok && dly_ms == '0 |=>
        st_ff.rst_st != RS_ON_DLY)
        else $error("zero delay step held the sequencer");
endmodule

// ### tb/srw_host_model.sv
module srw_host_model
(
    input wire logic clk_i,
    input wire logic run_i,
    output logic kick_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;

    // start quiet so no edge is seen before the bench asks for kicks
    initial
    begin
        kick_o = 1'b0;
        cnt = 0;
    end

    // toggle every 15 cycles: well inside a 3 ms timeout even after the pin synchroniser
    always @(posedge clk_i)
    begin
        cnt <= (cnt == 14) ? 0 : cnt + 1;
        if (run_i && cnt == 14)
        begin
            kick_o <= ~kick_o;
        end
    end
endmodule

// ### tb/system_reset_watchdog_tb_top.sv
`include "srw_cfg.svh"

module system_reset_watchdog_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import srw_pkg::*;
    localparam int T = 10;
    logic clk_i, nrst_i, kick_cmd_i, track_input_i, host_run, kick_pin;
    logic [`SRW_RAILS-1:0] pg_i, sel;
    srw_rst_cfg_t rst_cfg_i;
    srw_wd_cfg_t wd_cfg_i;
    logic sys_reset_o, timeout_output_o, wd_fire_o;
    srw_rst_st_t rst_state_o;
    srw_wd_st_t wd_state_o;
    int n_fail, num_checks, n, code, w, t;

    srw_top #(.TICK_CYC(T)) uut (.clk_i(clk_i), .nrst_i(nrst_i), .pg_i(pg_i), .rst_cfg_i(rst_cfg_i),
        .wd_cfg_i(wd_cfg_i), .kick_input_i(kick_pin), .kick_cmd_i(kick_cmd_i), .track_input_i(track_input_i),
        .sys_reset_o(sys_reset_o), .timeout_output_o(timeout_output_o), .wd_fire_o(wd_fire_o),
        .rst_state_o(rst_state_o), .wd_state_o(wd_state_o));

    srw_host_model host (.clk_i(clk_i), .run_i(host_run), .kick_o(kick_pin));

    // 125 MHz
    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // delay code model: zero, then one millisecond doubling
    function automatic int dly_ms(input int c);
        return c == 0 ? 0 : (1 << (c - 1));
    endfunction

    // a count restarted mid-tick may lose up to one tick, so the window opens a tick early
    function automatic int lo_cyc(input int ms);
        return ms == 0 ? 1 : (ms - 1) * T;
    endfunction

    function automatic logic pick(input int s);
        return s == 0 ? sys_reset_o : timeout_output_o;
    endfunction

    // first look is taken just after the edge, so a level launched by that edge counts as zero cycles
    task automatic wait_lvl(input int s, input logic val, output int cnt);
        cnt = 0;
        #1;
        while (pick(s) !== val && cnt < 5000)
        begin
            @(posedge clk_i);
            #1;
            cnt++;
        end
    endtask

    task automatic chk_lvl(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %0t level got %b want %b", $time, got, exp);
        end
    endtask

    task automatic chk_st(input logic [6:0] got, input logic [6:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %0t state got %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk_win(input int got, input int lo, input int hi);
        num_checks++;
        if (got < lo || got > hi)
        begin
            n_fail++;
            $display("ERROR %0t span %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // cut a hang short well past the expected few thousand cycles
    initial
    begin
        #160000;
        n_fail++;
        print_verdict();
    end

    // main sequence
    initial
    begin
        void'($urandom(19));
        sel = `SRW_RAILS'($urandom_range(1, 1023));
        nrst_i = 1'b0;
        pg_i = '0;
        // rails selected from the start, else an empty selection counts as good and reset releases at once
        rst_cfg_i = '0;
        rst_cfg_i.rail_sel = sel;
        wd_cfg_i = '0;
        kick_cmd_i = 1'b0;
        track_input_i = 1'b0;
        host_run = 1'b0;
        n_fail = 0;
        num_checks = 0;
        repeat (12) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        chk_lvl(sys_reset_o, 1'b1);
        chk_st(7'(rst_state_o), 7'(RS_WAIT));
        chk_lvl(timeout_output_o, 1'b0);
        // level mode: one missing rail holds reset, then release and reassert after the delay
        for (code = 0; code < 7; code++)
        begin
            @(posedge clk_i);
            rst_cfg_i <= '{rail_sel: sel, dly_sel: 5'(code), pulse_mode: 1'b0, width_ms: 16'h0002};
            pg_i <= (sel & (sel - 1)) | (~sel & `SRW_RAILS'($urandom));
            repeat (40) @(posedge clk_i);
            #1;
            chk_lvl(sys_reset_o, 1'b1);
            @(posedge clk_i);
            pg_i <= sel;
            wait_lvl(0, 1'b0, n);
            chk_win(n, lo_cyc(dly_ms(code)), dly_ms(code) * T + 4);
            chk_st(7'(rst_state_o), 7'(RS_UP));
            @(posedge clk_i);
            pg_i <= sel & (sel - 1);
            wait_lvl(0, 1'b1, n);
            chk_win(n, lo_cyc(dly_ms(code)), dly_ms(code) * T + 4);
        end
        // pulse mode: one pulse of the chosen width after a 2 ms delay
        w = $urandom_range(1, 5);
        @(posedge clk_i);
        rst_cfg_i.pulse_mode <= 1'b1;
        rst_cfg_i.dly_sel <= 5'h02;
        rst_cfg_i.width_ms <= 16'(w);
        repeat (3) @(posedge clk_i);
        #1;
        chk_lvl(sys_reset_o, 1'b0);
        @(posedge clk_i);
        pg_i <= sel;
        wait_lvl(0, 1'b1, n);
        chk_win(n, lo_cyc(2), 2 * T + 4);
        chk_st(7'(rst_state_o), 7'(RS_PULSE));
        wait_lvl(0, 1'b0, n);
        chk_win(n, lo_cyc(w), w * T + 4);
        @(posedge clk_i);
        pg_i <= sel & (sel - 1);
        repeat (50) @(posedge clk_i);
        #1;
        chk_lvl(sys_reset_o, 1'b0);
        // standalone timer kicked by the pin never expires
        t = $urandom_range(3, 5);
        @(posedge clk_i);
        rst_cfg_i.pulse_mode <= 1'b0;
        rst_cfg_i.dly_sel <= 5'h00;
        rst_cfg_i.width_ms <= 16'h0002;
        pg_i <= sel;
        wd_cfg_i <= '{enable: 1'b1, tie_reset: 1'b0, init_sel: 4'h0, timeout_ms: 16'(t), kick_pin_en: 1'b1,
                      track_en: 1'b0};
        host_run <= 1'b1;
        n = 0;
        repeat (300)
        begin
            @(posedge clk_i);
            #1;
            n += int'(timeout_output_o !== 1'b0);
        end
        chk_win(n, 0, 0);
        @(posedge clk_i);
        host_run <= 1'b0;
        wait_lvl(1, 1'b1, n);
        chk_win(n, (t - 1) * T - 15, t * T + 6);
        chk_lvl(wd_fire_o, 1'b1);
        chk_lvl(sys_reset_o, 1'b0);
        @(posedge clk_i);
        #1;
        chk_lvl(wd_fire_o, 1'b0);
        // the bus command clears an expired timer
        @(posedge clk_i);
        kick_cmd_i <= 1'b1;
        @(posedge clk_i);
        kick_cmd_i <= 1'b0;
        wait_lvl(1, 1'b0, n);
        chk_win(n, 0, 0);
        // pin kicks are ignored once the pin is deselected
        @(posedge clk_i);
        wd_cfg_i.kick_pin_en <= 1'b0;
        host_run <= 1'b1;
        wait_lvl(1, 1'b1, n);
        chk_win(n, (t - 1) * T - 5, t * T + 6);
        host_run <= 1'b0;
        // initial wait of 100 ms before the timeout phase
        @(posedge clk_i);
        wd_cfg_i.enable <= 1'b0;
        repeat (3) @(posedge clk_i);
        wd_cfg_i.enable <= 1'b1;
        wd_cfg_i.init_sel <= 4'h1;
        repeat (3) @(posedge clk_i);
        #1;
        chk_st(7'(wd_state_o), 7'(WD_INIT));
        wait_lvl(1, 1'b1, n);
        chk_win(n, (98 + t) * T - 4, (100 + t) * T + 6);
        // timer tied to system reset with release tracking the input pin
        @(posedge clk_i);
        wd_cfg_i <= '{enable: 1'b0, tie_reset: 1'b1, init_sel: 4'h0, timeout_ms: 16'(t), kick_pin_en: 1'b0,
                      track_en: 1'b1};
        repeat (3) @(posedge clk_i);
        wd_cfg_i.enable <= 1'b1;
        wait_lvl(0, 1'b1, n);
        chk_win(n, lo_cyc(t), t * T + 8);
        chk_st(7'(rst_state_o), 7'(RS_WD_RST));
        repeat (60) @(posedge clk_i);
        #1;
        chk_lvl(sys_reset_o, 1'b1);
        @(posedge clk_i);
        track_input_i <= 1'b1;
        wait_lvl(0, 1'b0, n);
        chk_win(n, 1, 8);
        // second expiry released after the fixed 2 ms width instead of the tracking pin
        @(posedge clk_i);
        wd_cfg_i.track_en <= 1'b0;
        track_input_i <= 1'b0;
        wait_lvl(0, 1'b1, n);
        chk_win(n, lo_cyc(t), t * T + 8);
        chk_st(7'(rst_state_o), 7'(RS_WD_RST));
        wait_lvl(0, 1'b0, n);
        chk_win(n, lo_cyc(2), 2 * T + 4);
        print_verdict();
    end
endmodule
